// ===== common/i2csba_map.vh
// Constants for the slave-side two-wire bus condition, address and acknowledge block
`ifndef I2CSBA_MAP_VH
`define I2CSBA_MAP_VH
`define I2CSBA_MODE_7B       4'h6
`define I2CSBA_MODE_10B      4'h7
`define I2CSBA_MODE_7B_SP    4'he
`define I2CSBA_MODE_10B_SP   4'hf
`define I2CSBA_TEN_PREFIX    5'h1e
`define I2CSBA_BIT_LAST      4'h7
`define I2CSBA_BIT_ACK       4'h8
`define I2CSBA_LSB_IGNORE    8'hfe
`define I2CSBA_BYTE_RST      8'h00
`define I2CSBA_CNT_FULL      2'h2
`endif

// ===== hw/i2csba_slave.v
// Slave-side two-wire bus logic: conditions, collision, address match, acknowledge, buffer
`timescale 1ns/10ps
`include "i2csba_map.vh"
// Behaviour
// RL1 - Bus is idle when no master holds it and both lines read high.
// RL2 - Start is SDA falling while SCL high; it makes the bus active.
// RL3 - Report a collision when SDA is already low where our Start drive begins; no Start is driven, a Start seen while we drive a low bit is flagged.
// RL4 - Collision whenever we release SDA expecting high but sample it low.
// RL5 - Stop is SDA rising while SCL high.
// RL6 - Stop accepted only after one SCL low since Start; else only Start.
// RL7 - Restart valid where Stop is; resets slave logic like a Start.
// RL8 - Ten-bit read needs prior full match, then Restart with high byte read.
// RL9 - Prior-match flag set on full ten-bit write match; cleared by three events.
// RL10 - Start and Stop enables add interrupts in modes lacking them.
// RL11 - Ninth pulse is acknowledge; transmitter releases, receiver pulls low.
// RL12 - Store the acknowledge level received from the master.
// RL13 - With hold enables set, software picks the acknowledge level driven.
// RL14 - With hold enables clear, hardware acknowledges automatically.
// RL15 - No acknowledge when buffer full or overflow already set.
// RL16 - Acknowledge-time bit set after eighth falling edge, only with hold enables.
// RL17 - Mode field selects seven or ten-bit, with or without Start/Stop interrupts.
// RL18 - Start/Stop interrupt modes flag Start, Restart and Stop.
// RL19 - First byte compared with masked address; on match buffered and flagged.
// RL20 - Mismatching first byte returns to idle silently.
// RL21 - Seven-bit mode ignores the address byte least significant bit.
// RL22 - After read address, all bytes go slave to master until Restart/Stop.
// RL23 - Pins are open drain: drive low or release only.
// RL24 - Master clocks; SDA changes while SCL low, sampled on SCL rising.
// RL25 - Lines synchronised to clk and edges found from synchronised samples.
module i2csba_slave (
	input  wire       clk,
	input  wire       nrst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        scl_out_q,
	output reg        scl_oe_n_q,
	output reg        sda_out_q,
	output reg        sda_oe_n_q,
	input  wire       port_enable_bit,
	input  wire [3:0] mode_select_field,
	input  wire [7:0] slave_address_reg,
	input  wire [1:0] slave_address_high,
	input  wire [7:0] address_mask,
	input  wire       address_hold_enable,
	input  wire       data_hold_enable,
	input  wire       ack_drive_value,
	input  wire       ack_release,
	input  wire       start_irq_enable,
	input  wire       stop_irq_enable,
	input  wire       irq_clear,
	input  wire       overflow_clear,
	input  wire       collision_clear,
	output reg  [7:0] rx_data_q,
	output reg        rx_valid_q,
	input  wire       rx_ready,
	input  wire [7:0] tx_data,
	input  wire       tx_valid,
	output reg        tx_ready_q,
	output reg        port_irq_flag_q,
	output reg        buffer_full_flag_q,
	output reg        receive_overflow_flag_q,
	output reg        bus_collision_q,
	output reg        ack_received_status_q,
	output reg        ack_time_status_q,
	output reg        start_seen_q,
	output reg        stop_seen_q,
	output reg        read_status_q,
	output reg        prior_match_q,
	output reg        bus_idle_q
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_HADR = 5'h02;
	localparam [4:0] ST_LADR = 5'h04;
	localparam [4:0] ST_RX   = 5'h08;
	localparam [4:0] ST_TX   = 5'h10;

	function is_ten;
		input [3:0] m;
		is_ten = (m == `I2CSBA_MODE_10B) || (m == `I2CSBA_MODE_10B_SP);
	endfunction

	function is_sp;
		input [3:0] m;
		is_sp = (m == `I2CSBA_MODE_7B_SP) || (m == `I2CSBA_MODE_10B_SP);
	endfunction

	function mode_ok;
		input [3:0] m;
		mode_ok = is_ten(m) || (m == `I2CSBA_MODE_7B) || (m == `I2CSBA_MODE_7B_SP);
	endfunction

	reg        scl_m_q;
	reg        scl_s_q;
	reg        scl_p_q;
	reg        sda_m_q;
	reg        sda_s_q;
	reg        sda_p_q;
	reg  [4:0] state_q;
	reg  [4:0] next_q;
	reg  [3:0] bit_q;
	reg  [7:0] shift_q;
	reg        ack_low_q;
	reg        hold_q;
	reg        nack_q;
	reg        tx_have_q;
	reg        busy_q;
	reg        low_seen_q;
	reg        push_q;
	reg  [7:0] push_byte_q;
	reg  [7:0] ent1_q;
	reg  [1:0] cnt_q;
	reg  [1:0] cnt_d;

	// Only the second and third flops of each three-flop chain feed logic
	wire en        = port_enable_bit && mode_ok(mode_select_field);
	wire scl_rise  = scl_s_q && !scl_p_q; // RL24
	wire scl_fall  = !scl_s_q && scl_p_q;
	wire start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // RL2
	wire stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q && low_seen_q; // RL5 RL6
	wire sp_irq_st = is_sp(mode_select_field) || start_irq_enable; // RL10 RL18
	wire sp_irq_sp = is_sp(mode_select_field) || stop_irq_enable; // RL10 RL18
	wire full      = (cnt_q == `I2CSBA_CNT_FULL);
	wire refuse    = full || receive_overflow_flag_q;
	wire byte_end  = scl_fall && (bit_q == `I2CSBA_BIT_LAST);
	wire ack_end   = scl_fall && (bit_q == `I2CSBA_BIT_ACK);
	wire hold_en   = address_hold_enable || data_hold_enable;
	wire m7        = ((shift_q ^ slave_address_reg) & address_mask & `I2CSBA_LSB_IGNORE)
	                 == `I2CSBA_BYTE_RST; // RL21
	wire mlow      = ((shift_q ^ slave_address_reg) & address_mask) == `I2CSBA_BYTE_RST;
	wire mhigh     = shift_q[7:1] == {`I2CSBA_TEN_PREFIX, slave_address_high};
	wire take_tx   = tx_valid && tx_ready_q && (state_q == ST_TX);
	wire pop       = rx_valid_q && rx_ready;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_in; // RL25
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// Accepting one byte: push it or refuse it, then arrange the acknowledge slot
	task accept;
		input       is_addr;
		input [4:0] nxt;
		begin
			next_q <= nxt;
			port_irq_flag_q <= 1'b1; // RL19
			if (full) begin
				receive_overflow_flag_q <= 1'b1;
			end
			if (!refuse) begin
				push_q <= 1'b1; // RL19
				push_byte_q <= shift_q;
			end
			nack_q <= refuse; // RL15
			if ((is_addr && address_hold_enable) || (!is_addr && data_hold_enable)) begin
				hold_q <= 1'b1; // RL13
			end else begin
				ack_low_q <= !refuse; // RL14 RL15
			end
		end
	endtask

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			next_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= `I2CSBA_BYTE_RST;
			ack_low_q <= 1'b0;
			hold_q <= 1'b0;
			nack_q <= 1'b0;
			tx_have_q <= 1'b0;
			busy_q <= 1'b0;
			low_seen_q <= 1'b0;
			push_q <= 1'b0;
			push_byte_q <= `I2CSBA_BYTE_RST;
			tx_ready_q <= 1'b0;
			port_irq_flag_q <= 1'b0;
			receive_overflow_flag_q <= 1'b0;
			bus_collision_q <= 1'b0;
			ack_received_status_q <= 1'b0;
			ack_time_status_q <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
			read_status_q <= 1'b0;
			prior_match_q <= 1'b0;
			bus_idle_q <= 1'b0;
		end else begin
			// Clears first so that a set later in this cycle wins
			port_irq_flag_q <= port_irq_flag_q && !irq_clear;
			receive_overflow_flag_q <= receive_overflow_flag_q && !overflow_clear;
			bus_collision_q <= bus_collision_q && !collision_clear;
			push_q <= 1'b0;
			bus_idle_q <= !busy_q && scl_s_q && sda_s_q; // RL1
			tx_ready_q <= en && (state_q == ST_TX) && !tx_have_q && !take_tx &&
			              (bit_q == 4'h0);
			if (!en) begin
				state_q <= ST_IDLE;
				bit_q <= 4'h0;
				ack_low_q <= 1'b0;
				hold_q <= 1'b0;
				tx_have_q <= 1'b0;
				busy_q <= 1'b0;
				low_seen_q <= 1'b0;
				ack_time_status_q <= 1'b0;
				prior_match_q <= 1'b0;
			end else if (start_det) begin
				// Restart takes this same path and keeps the prior match
				if (state_q == ST_TX && tx_have_q && !shift_q[7]) begin
					bus_collision_q <= 1'b1; // RL3
				end
				state_q <= ST_HADR; // RL7
				bit_q <= 4'h0;
				ack_low_q <= 1'b0;
				hold_q <= 1'b0;
				tx_have_q <= 1'b0;
				ack_time_status_q <= 1'b0;
				busy_q <= 1'b1; // RL2
				low_seen_q <= 1'b0;
				start_seen_q <= 1'b1;
				stop_seen_q <= 1'b0;
				if (sp_irq_st) begin
					port_irq_flag_q <= 1'b1; // RL18
				end
			end else if (stop_det) begin
				state_q <= ST_IDLE; // RL22
				bit_q <= 4'h0;
				ack_low_q <= 1'b0;
				hold_q <= 1'b0;
				tx_have_q <= 1'b0;
				ack_time_status_q <= 1'b0;
				busy_q <= 1'b0;
				start_seen_q <= 1'b0;
				stop_seen_q <= 1'b1;
				prior_match_q <= 1'b0; // RL9
				if (sp_irq_sp) begin
					port_irq_flag_q <= 1'b1; // RL18
				end
			end else begin
				if (busy_q && !scl_s_q) begin
					low_seen_q <= 1'b1; // RL6
				end
				if (hold_q && ack_release) begin
					hold_q <= 1'b0;
					ack_low_q <= !ack_drive_value && !nack_q; // RL13 RL15
				end
				if (take_tx) begin
					tx_have_q <= 1'b1;
					shift_q <= tx_data;
				end
				if (state_q == ST_TX) begin
					if (scl_rise && bit_q != `I2CSBA_BIT_ACK && tx_have_q && shift_q[7] &&
					    !sda_s_q) begin
						bus_collision_q <= 1'b1; // RL4
						state_q <= ST_IDLE;
						tx_have_q <= 1'b0;
					end else if (scl_rise && bit_q == `I2CSBA_BIT_ACK) begin
						ack_received_status_q <= sda_s_q; // RL12
					end else if (ack_end) begin
						bit_q <= 4'h0;
						tx_have_q <= 1'b0;
						port_irq_flag_q <= 1'b1;
						if (ack_received_status_q) begin
							state_q <= ST_IDLE;
						end
					end else if (scl_fall && tx_have_q) begin
						// Next bit goes out while SCL is low
						shift_q <= {shift_q[6:0], 1'b1};
						bit_q <= bit_q + 4'h1;
					end
				end else if (state_q != ST_IDLE) begin
					if (scl_rise && bit_q != `I2CSBA_BIT_ACK) begin
						shift_q <= {shift_q[6:0], sda_s_q}; // RL24
					end else if (ack_end) begin
						// Release SDA after the ninth pulse
						bit_q <= 4'h0; // RL11
						ack_low_q <= 1'b0;
						ack_time_status_q <= 1'b0;
						state_q <= next_q;
					end else if (byte_end) begin
						bit_q <= `I2CSBA_BIT_ACK;
						if (hold_en && state_q != ST_HADR || hold_en && (m7 || mhigh)) begin
							ack_time_status_q <= 1'b1; // RL16
						end
						if (state_q == ST_RX) begin
							accept(1'b0, ST_RX);
						end else if (state_q == ST_LADR) begin
							if (mlow) begin
								prior_match_q <= 1'b1; // RL9
								accept(1'b1, ST_RX);
							end else begin
								state_q <= ST_IDLE; // RL20
								ack_time_status_q <= 1'b0;
							end
						end else if (!is_ten(mode_select_field)) begin
							if (m7) begin
								read_status_q <= shift_q[0];
								accept(1'b1, shift_q[0] ? ST_TX : ST_RX); // RL19 RL22
							end else begin
								state_q <= ST_IDLE; // RL20
							end
						end else if (mhigh && !shift_q[0]) begin
							prior_match_q <= 1'b0; // RL9
							read_status_q <= 1'b0;
							accept(1'b1, ST_LADR); // RL17
						end else if (mhigh && prior_match_q) begin
							read_status_q <= 1'b1;
							accept(1'b1, ST_TX); // RL8
						end else begin
							prior_match_q <= 1'b0; // RL9
							state_q <= ST_IDLE; // RL20
							ack_time_status_q <= 1'b0;
						end
					end else if (scl_fall && low_seen_q) begin
						// The Start's own SCL fall carries no bit, so it is not counted
						bit_q <= bit_q + 4'h1;
					end
				end
			end
		end
	end

	// Two-entry receive buffer; ent1 only ever holds the younger word
	always @* begin
		cnt_d = cnt_q;
		if (push_q && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push_q) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 2'h0;
			rx_data_q <= `I2CSBA_BYTE_RST;
			ent1_q <= `I2CSBA_BYTE_RST;
			rx_valid_q <= 1'b0;
			buffer_full_flag_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rx_valid_q <= (cnt_d != 2'h0);
			buffer_full_flag_q <= (cnt_d == `I2CSBA_CNT_FULL); // RL15
			if (pop) begin
				rx_data_q <= (push_q && cnt_q == 2'h1) ? push_byte_q : ent1_q;
				if (push_q && cnt_q == `I2CSBA_CNT_FULL) begin
					ent1_q <= push_byte_q;
				end
			end else if (push_q) begin
				if (cnt_q == 2'h0) begin
					rx_data_q <= push_byte_q;
				end else begin
					ent1_q <= push_byte_q;
				end
			end
		end
	end

	// Open-drain pins: the level driven is always low, only the enable moves
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_out_q <= 1'b0;
			sda_out_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else begin
			scl_out_q <= 1'b0; // RL23
			sda_out_q <= 1'b0; // RL23
			scl_oe_n_q <= !(en && (hold_q ||
			              (state_q == ST_TX && !tx_have_q && bit_q == 4'h0)));
			sda_oe_n_q <= !(en && (ack_low_q || (state_q == ST_TX && tx_have_q &&
			              bit_q != `I2CSBA_BIT_ACK && !shift_q[7]))); // RL11
		end
	end
endmodule

// ===== verification/i2csba_chk.sv
// Assertion checker for the slave-side two-wire bus block
`timescale 1ns/10ps
`include "i2csba_map.vh"
module i2csba_chk (
	input logic       clk,
	input logic       nrst,
	input logic [3:0] mode_select_field,
	input logic       address_hold_enable,
	input logic       data_hold_enable,
	input logic       start_irq_enable,
	input logic       collision_clear,
	input logic       scl_out_q,
	input logic       scl_oe_n_q,
	input logic       sda_out_q,
	input logic       sda_oe_n_q,
	input logic       rx_valid_q,
	input logic       port_irq_flag_q,
	input logic       buffer_full_flag_q,
	input logic       receive_overflow_flag_q,
	input logic       bus_collision_q,
	input logic       ack_time_status_q,
	input logic       start_seen_q,
	input logic       stop_seen_q,
	input logic       bus_idle_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	open_drain_a: assert property (!scl_out_q && !sda_out_q)
		else $error("pin driven high");
	idle_release_a: assert property (bus_idle_q |-> scl_oe_n_q && sda_oe_n_q)
		else $error("pin pulled while idle");
	sp_irq_a: assert property ($rose(start_seen_q) &&
		mode_select_field == `I2CSBA_MODE_7B_SP |-> ##[0:2] port_irq_flag_q)
		else $error("no flag on start");
	no_sp_irq_a: assert property ($rose(start_seen_q) && !$past(port_irq_flag_q) &&
		mode_select_field == `I2CSBA_MODE_7B && !start_irq_enable |-> !port_irq_flag_q [*2])
		else $error("flag on start in plain mode");
	cond_excl_a: assert property (!(start_seen_q && stop_seen_q))
		else $error("start and stop both shown");
	full_valid_a: assert property (buffer_full_flag_q |-> rx_valid_q)
		else $error("full without valid word");
	ovf_full_a: assert property ($rose(receive_overflow_flag_q) |-> $past(buffer_full_flag_q))
		else $error("overflow while not full");
	ack_time_a: assert property ($rose(ack_time_status_q) |->
		$past(address_hold_enable) || $past(data_hold_enable))
		else $error("ack time without hold");
	coll_hold_a: assert property (bus_collision_q && !collision_clear |=> bus_collision_q)
		else $error("collision flag lost");
endmodule
bind i2csba_slave i2csba_chk i2csba_chk_inst (.*);

// ===== verification/i2csba_master.sv
// Bus master model: open drain, 200 ns bit time, waits out clock stretching
`timescale 1ns/10ps
module i2csba_master (
	input  wire  scl_w,
	input  wire  sda_w,
	output logic m_scl,
	output logic m_sda
);
	initial begin
		m_scl = 1'b1;
		m_sda = 1'b1;
	end
	// Non-blocking drive so an edge landing on the slave clock never races its flops
	task automatic start();
		m_sda <= 1'b0;
		#100;
		m_scl <= 1'b0;
	endtask
	task automatic glitch();
		m_sda <= 1'b0;
		#100;
		m_sda <= 1'b1;
		#100;
	endtask
	task automatic bit_io(input logic b, output logic s);
		#50;
		m_sda <= b;
		#50;
		m_scl <= 1'b1;
		// Let a stretch that begins in this same step settle before looking
		#1;
		wait (scl_w === 1'b1);
		#50;
		s = sda_w;
		#50;
		m_scl <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ak, a);
	endtask
	task automatic stop();
		#50;
		m_sda <= 1'b0;
		#50;
		m_scl <= 1'b1;
		#1;
		wait (scl_w === 1'b1);
		#50;
		m_sda <= 1'b1;
		#50;
	endtask
endmodule

// ===== verification/tb_i2csba_slave.sv
// Self-checking bench for the slave-side two-wire bus block
`timescale 1ns/10ps
`include "i2csba_map.vh"
module tb_i2csba_slave;
	logic       clk, nrst, port_enable_bit, address_hold_enable, data_hold_enable;
	logic       ack_drive_value, ack_release, start_irq_enable, stop_irq_enable, irq_clear;
	logic       overflow_clear, collision_clear, rx_ready, tx_valid, ak, m_scl, m_sda;
	logic       scl_out_q, scl_oe_n_q, sda_out_q, sda_oe_n_q, rx_valid_q, tx_ready_q;
	logic       port_irq_flag_q, buffer_full_flag_q, receive_overflow_flag_q, bus_collision_q;
	logic       ack_received_status_q, ack_time_status_q, start_seen_q, stop_seen_q;
	logic       read_status_q, prior_match_q, bus_idle_q;
	logic [3:0] mode_select_field;
	logic [1:0] slave_address_high;
	logic [7:0] slave_address_reg, address_mask, tx_data, rx_data_q, rd;
	int         errors = 0;
	int         n_checks = 0;
	wire        scl_in = (scl_oe_n_q | scl_out_q) & m_scl;
	wire        sda_in = (sda_oe_n_q | sda_out_q) & m_sda;
	// Mode, own address, mask, address byte sent, acknowledge level expected
	logic [28:0] rows [6] = '{
		{`I2CSBA_MODE_7B, 8'ha4, 8'hff, 8'ha4, 1'b0},
		{`I2CSBA_MODE_7B, 8'ha5, 8'hff, 8'ha4, 1'b0},
		{`I2CSBA_MODE_7B, 8'ha4, 8'hff, 8'ha6, 1'b1},
		{`I2CSBA_MODE_7B_SP, 8'h30, 8'hff, 8'h30, 1'b0},
		{`I2CSBA_MODE_10B_SP, 8'h00, 8'hff, 8'hf2, 1'b0},
		{`I2CSBA_MODE_7B, 8'ha4, 8'hf0, 8'ha8, 1'b0}
	};
	i2csba_slave i2csba_slave_inst (.*);
	i2csba_master i2csba_master_inst (.scl_w(scl_in), .sda_w(sda_in), .m_scl, .m_sda);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Receiver stalls by default; words leave only through this pop
	task automatic pop(input logic [7:0] exp);
		@(negedge clk);
		chk("rx_valid", rx_valid_q, 1'b1);
		chk("rx_data", rx_data_q, exp);
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic offer(input logic [7:0] d);
		@(posedge clk);
		tx_data <= d;
		tx_valid <= 1'b1;
		// At least one edge passes, so valid never rises and falls in one step
		for (int k = 0; k < 4000; k++) begin
			@(posedge clk);
			if (tx_ready_q === 1'b1)
				break;
		end
		tx_valid <= 1'b0;
	endtask
	task automatic fin(input string nm);
		repeat (6) @(negedge clk);
		chk("stop", stop_seen_q, 1'b1);
		chk("idle", bus_idle_q, 1'b1);
		@(posedge clk);
		{irq_clear, overflow_clear, collision_clear} <= 3'h7;
		@(posedge clk);
		{irq_clear, overflow_clear, collision_clear} <= 3'h0;
		$display("test %s done", nm);
	endtask
	initial begin
		#300us;
		errors++;
		stop_test();
	end
	initial begin
		{nrst, port_enable_bit, address_hold_enable, data_hold_enable, ack_drive_value,
		 ack_release, start_irq_enable, stop_irq_enable, irq_clear, overflow_clear,
		 collision_clear, rx_ready, tx_valid, mode_select_field, slave_address_reg,
		 address_mask, tx_data} = '0;
		slave_address_high = 2'h1;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(negedge clk);
		chk("idle", bus_idle_q, 1'b1);
		chk("pins", {scl_oe_n_q, sda_oe_n_q}, 2'h3);
		@(posedge clk);
		port_enable_bit <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk);
			{mode_select_field, slave_address_reg, address_mask} <= rows[i][28:9];
			@(posedge clk);
			i2csba_master_inst.start();
			@(negedge clk);
			chk("start", start_seen_q, 1'b1);
			i2csba_master_inst.xfer(rows[i][8:1], 1'b1, rd, ak);
			chk("ack", ak, rows[i][0]);
			@(negedge clk);
			chk("irq", port_irq_flag_q, !rows[i][0]);
			chk("rx_valid", rx_valid_q, !rows[i][0]);
			if (!rows[i][0])
				pop(rows[i][8:1]);
			i2csba_master_inst.stop();
			fin("row");
		end
		start_irq_enable <= 1'b1;
		@(posedge clk);
		i2csba_master_inst.glitch();
		@(negedge clk);
		chk("start_only", {start_seen_q, stop_seen_q}, 2'h2);
		chk("start_irq", port_irq_flag_q, 1'b1);
		@(posedge clk);
		start_irq_enable <= 1'b0;
		// Receiver stalls until two words wait, the third is refused
		i2csba_master_inst.start();
		for (int i = 0; i < 3; i++) begin
			i2csba_master_inst.xfer(8'ha4 + 8'(i), 1'b1, rd, ak);
			chk("full_ack", ak, i == 2);
		end
		@(negedge clk);
		chk("flags", {buffer_full_flag_q, receive_overflow_flag_q}, 2'h3);
		i2csba_master_inst.stop();
		pop(8'ha4);
		pop(8'ha5);
		chk("empty", rx_valid_q, 1'b0);
		fin("overflow");
		for (int c = 0; c < 2; c++) begin
			fork
				begin
					i2csba_master_inst.start();
					i2csba_master_inst.xfer(8'ha5, 1'b1, rd, ak);
					i2csba_master_inst.xfer(c ? 8'h00 : 8'hff, 1'b0, rd, ak);
					chk("tx0", rd, c ? 8'h00 : 8'h3c);
					chk("ack_lat", ack_received_status_q, 8'(c));
					i2csba_master_inst.xfer(8'hff, 1'b1, rd, ak);
					chk("tx1", rd, c ? 8'hff : 8'hc3);
				end
				begin
					offer(c ? 8'hff : 8'h3c);
					if (!c)
						offer(8'hc3);
				end
			join
			@(negedge clk);
			chk("ack_stat", ack_received_status_q, 1'b1);
			chk("coll", bus_collision_q, c);
			chk("rw", read_status_q, 1'b1);
			i2csba_master_inst.stop();
			pop(8'ha5);
			fin("read");
		end
		@(posedge clk);
		{mode_select_field, slave_address_reg} <= {`I2CSBA_MODE_10B, 8'h5a};
		@(posedge clk);
		i2csba_master_inst.start();
		i2csba_master_inst.xfer(8'hf2, 1'b1, rd, ak);
		i2csba_master_inst.xfer(8'h5a, 1'b1, rd, ak);
		@(negedge clk);
		chk("prior", prior_match_q, 1'b1);
		i2csba_master_inst.stop();
		pop(8'hf2);
		pop(8'h5a);
		chk("prior_clr", prior_match_q, 1'b0);
		fin("ten_bit");
		@(posedge clk);
		{mode_select_field, slave_address_reg, address_hold_enable, ack_drive_value} <=
			{`I2CSBA_MODE_7B, 8'ha4, 2'h3};
		fork
			begin
				i2csba_master_inst.start();
				i2csba_master_inst.xfer(8'ha4, 1'b1, rd, ak);
				chk("sw_ack", ak, 1'b1);
			end
			begin
				for (int k = 0; k < 800 && ack_time_status_q !== 1'b1; k++)
					@(negedge clk);
				// The stretch shows one edge after the status bit
				@(negedge clk);
				chk("hold", {ack_time_status_q, scl_oe_n_q}, 2'h2);
				@(posedge clk);
				ack_release <= 1'b1;
				@(posedge clk);
				ack_release <= 1'b0;
			end
		join
		i2csba_master_inst.stop();
		fin("hold");
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(negedge clk);
		chk("rst_state", {port_irq_flag_q, rx_valid_q, bus_idle_q, scl_oe_n_q}, 4'h3);
		$display("test reset done");
		stop_test();
	end
endmodule
